// File: core/sf_sup_pkg.sv
// package: constants and types for the sf supervision logic
`default_nettype none
package sf_sup_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS         = 1000000;
   localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
   localparam int DIV_W         = 15;
   localparam int CNT_W         = 10;

   // all delays in milliseconds, counted on the 1 ms tick
   localparam logic [CNT_W-1:0] BSF_INSERT_MS = 10'h00D; // 13 ms
   localparam logic [CNT_W-1:0] BSF_REMOVE_MS = 10'h032; // 50 ms
   localparam logic [CNT_W-1:0] TONE_BOOST_MS = 10'h190; // 400 ms
   localparam logic [CNT_W-1:0] PRECUT_MS     = 10'h00F; // 15 ms
   localparam logic [CNT_W-1:0] DIAL_HANG_MS  = 10'h07D; // 125 ms, also the pulse gap limit
   localparam logic [CNT_W-1:0] SEIZE_HOLD_MS = 10'h07D; // 125 ms
   localparam logic [CNT_W-1:0] LOCAL_DISC_MS = 10'h271; // 625 ms

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      EM_TYPE_1   = 2'h0,
      EM_TYPE_2   = 2'h1,
      EM_TYPE_3   = 2'h2,
      EM_TYPE_RSV = 2'h3
   } em_type_e;

   typedef struct packed {
      logic m_lead_gnd;
      logic e_lead_gnd;
      logic relay;
      logic tone_send;
      logic tone_high;
      logic xmt_cut;
      logic bsf_in;
      logic cfg_err;
   } sup_out_s;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic             tick;
      logic             prev_tone;
      logic             prev_busy;
      logic [CNT_W-1:0] ins;
      logic [CNT_W-1:0] rem;
      logic [CNT_W-1:0] boost;
      logic [CNT_W-1:0] precut;
      logic [CNT_W-1:0] hang;
      logic [CNT_W-1:0] seize;
      logic [CNT_W-1:0] disc;
      logic             dial_act;
      logic             far_disc;
      sup_out_s         out;
   } sup_state_s;

   // idle: tone sent, path cut, filter in
   localparam sup_out_s RESET_OUT = '{m_lead_gnd: 1'b0, e_lead_gnd: 1'b0, relay: 1'b0, tone_send: 1'b1,
                                      tone_high: 1'b0, xmt_cut: 1'b1, bsf_in: 1'b1, cfg_err: 1'b0};
endpackage
`default_nettype wire

// File: core/sf_supervision.sv
// module: supervisory signaling logic between an sf facility and an e&m trunk
`default_nettype none

// How it works
// - b-side: m output grounded while tone detected
// - b-side: send tone while e lead open
// - b-side with type three interface is rejected
// - b-side: relay energized while tone detected
// - insert receive filter 13 ms after tone
// - high tone level: dialing and first 400 ms
// - path cut while idle, restored on busy
// - path cut during dialing either direction
// - incoming lead transition while off-hook: brief cut
// - local dialing: precut, hold, 125 ms hang
// - remove receive filter 50 ms after tone stops
// - seizure hold, distant cut, local disconnect cut
// - a-side: e output open while tone detected
// - a-side: send tone unless m lead negative
module sf_supervision
   import sf_sup_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input  wire logic     mclk_in,
   input  wire logic     sys_rst_in,
   input  wire logic     tone_det_in,
   input  wire logic     m_lead_neg_in,
   input  wire logic     e_lead_gnd_in,
   input  wire logic     b_side_in,
   input  wire em_type_e em_type_in,
   output var  sup_out_s sup_out
);

   sup_state_s st;
   sup_state_s nxt;
   logic       b_eff;
   logic       in_busy;
   logic       tone_rise;
   logic       tone_fall;
   logic       busy_edge;
   logic       busy_rise;
   logic       from_idle;

   function automatic logic [CNT_W-1:0] dec(input logic tick, input logic [CNT_W-1:0] c);
      dec = (tick && c != '0) ? c - 1'b1 : c;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      nxt       = st;
      // a rejected b-side setting falls back to a-side leads
      b_eff     = b_side_in && (em_type_in != EM_TYPE_3);
      in_busy   = b_eff ? e_lead_gnd_in : m_lead_neg_in;
      tone_rise = tone_det_in && !st.prev_tone;
      tone_fall = !tone_det_in && st.prev_tone;
      busy_edge = in_busy != st.prev_busy;
      busy_rise = in_busy && !st.prev_busy;
      from_idle = !st.prev_busy && st.disc == '0;

      nxt.prev_tone = tone_det_in;
      nxt.prev_busy = in_busy;

      // one millisecond tick drives every timer
      nxt.tick = 1'b0;
      if (st.div == DIV_W'(TICK_CYCLES_P - 1)) begin
         nxt.div  = '0;
         nxt.tick = 1'b1;
      end else begin
         nxt.div = st.div + 1'b1;
      end
      nxt.ins    = dec(st.tick, st.ins);
      nxt.rem    = dec(st.tick, st.rem);
      nxt.boost  = dec(st.tick, st.boost);
      nxt.precut = dec(st.tick, st.precut);
      nxt.hang   = dec(st.tick, st.hang);
      nxt.seize  = dec(st.tick, st.seize);
      nxt.disc   = dec(st.tick, st.disc);

      // receive filter timing
      if (st.tick && st.ins == 10'h001) begin
         nxt.out.bsf_in = 1'b1;
      end
      if (st.tick && st.rem == 10'h001) begin
         nxt.out.bsf_in = 1'b0;
      end
      if (tone_rise) begin
         nxt.ins = BSF_INSERT_MS;
         nxt.rem = '0;
      end
      if (tone_fall) begin
         nxt.rem = BSF_REMOVE_MS;
         nxt.ins = '0;
      end

      // dial pulse tracking; the hang timer doubles as the gap limit
      if (st.tick && st.hang == 10'h001) begin
         nxt.dial_act = 1'b0;
      end
      if ((busy_edge && !from_idle) || ((tone_rise || tone_fall) && in_busy)) begin
         if (st.hang != '0) begin
            nxt.dial_act = 1'b1;
         end
         nxt.hang = DIAL_HANG_MS;
      end
      if (busy_edge && !from_idle) begin
         nxt.precut = PRECUT_MS;
      end
      if (busy_rise && from_idle) begin
         nxt.seize = SEIZE_HOLD_MS;
      end
      if (busy_edge && !in_busy) begin
         nxt.disc = LOCAL_DISC_MS;
      end

      // tone returning while busy means the far end has hung up
      if (tone_rise && in_busy && st.seize == '0) begin
         nxt.far_disc = 1'b1;
      end
      if (tone_fall || !in_busy) begin
         nxt.far_disc = 1'b0;
      end

      // outgoing tone and level
      nxt.out.tone_send = !in_busy;
      if (!in_busy && !st.out.tone_send) begin
         nxt.boost = TONE_BOOST_MS;
      end
      nxt.out.tone_high = nxt.out.tone_send && (nxt.boost != '0 || nxt.dial_act);

      // transmit path cut
      nxt.out.xmt_cut = (!in_busy && nxt.disc == '0)
                        || nxt.precut != '0 || nxt.seize != '0 || nxt.dial_act || nxt.far_disc;

      // terminal leads
      nxt.out.m_lead_gnd = b_eff && tone_det_in;
      nxt.out.e_lead_gnd = !b_eff && !tone_det_in;
      nxt.out.relay      = b_eff ? tone_det_in : !tone_det_in;
      nxt.out.cfg_err    = b_side_in && (em_type_in == EM_TYPE_3);
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st           <= '0;
         st.prev_tone <= 1'b0;
         st.out       <= RESET_OUT;
      end else begin
         st <= nxt;
      end
   end

   assign sup_out = st.out;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence busy_edge_s;
      busy_edge && !from_idle;
   endsequence

   sequence seize_s;
      busy_rise && from_idle;
   endsequence

   sequence tone_up_s;
      !sup_out.tone_send ##1 sup_out.tone_send;
   endsequence

   m_lead_b_a : assert property (b_eff |=> sup_out.m_lead_gnd == $past(tone_det_in))
      else $error("m lead output does not follow tone on b-side");
   tone_send_a : assert property (##1 sup_out.tone_send == !$past(in_busy))
      else $error("tone send does not follow incoming lead");
   cfg_reject_a : assert property (sup_out.cfg_err |-> !sup_out.m_lead_gnd)
      else $error("b-side with type three still driven as b-side");
   relay_b_a : assert property (b_eff |=> sup_out.relay == $past(tone_det_in))
      else $error("relay not energized with tone on b-side");
   bsf_insert_a : assert property ($rose(sup_out.bsf_in) |-> $past(st.tick && st.ins == 10'h001))
      else $error("receive filter inserted off schedule");
   tone_boost_a : assert property (tone_up_s |-> sup_out.tone_high ##1 sup_out.tone_high [*8])
      else $error("tone not at high level after tone start");
   idle_cut_a : assert property ((!in_busy && !st.prev_busy && st.disc == '0) |=> sup_out.xmt_cut)
      else $error("path not cut while idle");
   dial_cut_a : assert property (st.dial_act |-> sup_out.xmt_cut)
      else $error("path not cut during dialing");
   precut_a : assert property (busy_edge_s |=> st.precut == PRECUT_MS && sup_out.xmt_cut)
      else $error("no precut on incoming lead transition");
   bsf_remove_a : assert property ($fell(sup_out.bsf_in) |-> $past(st.tick && st.rem == 10'h001))
      else $error("receive filter removed off schedule");
   seize_hold_a : assert property (seize_s |=> sup_out.xmt_cut [*8])
      else $error("path not held cut after seizure");
   tick_pulse_a : assert property (st.tick |-> st.div == '0 ##1 !st.tick)
      else $error("timer tick not a single pulse at divider wrap");

   sequence tone_rise_s;
      tone_det_in && !st.prev_tone;
   endsequence

   sequence tone_fall_s;
      !tone_det_in && st.prev_tone;
   endsequence

   sequence break_s;
      busy_edge && !in_busy;
   endsequence

   sequence far_disc_s;
      tone_rise && in_busy && st.seize == '0;
   endsequence

   // ==========================================================
   // terminal leads and configuration
   // the unused output lead must stay quiet, or both sides would signal at once
   e_lead_open_a : assert property (!b_eff |=> sup_out.e_lead_gnd == !$past(tone_det_in))
      else $error("e lead output does not follow tone on a-side");
   m_lead_off_a : assert property (!b_eff |=> !sup_out.m_lead_gnd)
      else $error("m lead output driven on a-side");
   e_out_off_a : assert property (b_eff |=> !sup_out.e_lead_gnd)
      else $error("e lead output driven on b-side");
   relay_a_side_a : assert property (!b_eff |=> sup_out.relay == !$past(tone_det_in))
      else $error("relay not energized without tone on a-side");
   tone_b_a : assert property (b_eff |=> sup_out.tone_send == !$past(e_lead_gnd_in))
      else $error("tone send does not follow e lead on b-side");
   tone_a_a : assert property (!b_eff |=> sup_out.tone_send == !$past(m_lead_neg_in))
      else $error("tone send does not follow m lead on a-side");
   cfg_flag_a : assert property (##1 sup_out.cfg_err == $past(b_side_in && em_type_in == EM_TYPE_3))
      else $error("configuration error flag wrong");
   cfg_fallback_a : assert property ((b_side_in && em_type_in == EM_TYPE_3) |-> !b_eff)
      else $error("b-side with type three not rejected");

   // ==========================================================
   // receive filter
   // each tone edge cancels the opposite timer, so a short blip cannot flip the filter late
   ins_load_a : assert property (tone_rise_s |=> st.ins == BSF_INSERT_MS)
      else $error("insert timer not loaded on tone rise");
   rem_clear_a : assert property (tone_rise_s |=> st.rem == '0)
      else $error("remove timer not cleared on tone rise");
   rem_load_a : assert property (tone_fall_s |=> st.rem == BSF_REMOVE_MS)
      else $error("remove timer not loaded on tone fall");
   ins_clear_a : assert property (tone_fall_s |=> st.ins == '0)
      else $error("insert timer not cleared on tone fall");
   bsf_keep_a : assert property ((tone_det_in && st.prev_tone && st.rem == '0 && sup_out.bsf_in) |=> sup_out.bsf_in)
      else $error("receive filter dropped while tone steady");
   bsf_out_a : assert property ((!tone_det_in && !st.prev_tone && st.ins == '0 && !sup_out.bsf_in) |=> !sup_out.bsf_in)
      else $error("receive filter inserted without tone");

   // ==========================================================
   // tone level
   // boost restarts on every tone application, not only the first after idle
   boost_load_a : assert property ((!in_busy && !sup_out.tone_send) |=> st.boost == TONE_BOOST_MS)
      else $error("boost timer not loaded at tone start");
   tone_level_a : assert property (sup_out.tone_high == (sup_out.tone_send && (st.boost != '0 || st.dial_act)))
      else $error("tone level wrong");
   tone_low_a : assert property (!sup_out.tone_send |-> !sup_out.tone_high)
      else $error("high level without tone");
   idle_low_a : assert property ((sup_out.tone_send && st.boost == '0 && !st.dial_act) |-> !sup_out.tone_high)
      else $error("tone not at low idle level");
   dial_high_a : assert property ((st.dial_act && sup_out.tone_send) |-> sup_out.tone_high)
      else $error("tone not at high level during dialing");

   // ==========================================================
   // transmit path
   // every cut must have a live cause, otherwise the path could stay dead in talk state
   hang_load_a : assert property (busy_edge_s |=> st.hang == DIAL_HANG_MS)
      else $error("hang timer not loaded on lead transition");
   dial_set_a : assert property ((busy_edge && !from_idle && st.hang != '0) |=> st.dial_act)
      else $error("dialing not detected on fast transitions");
   seize_load_a : assert property (seize_s |=> st.seize == SEIZE_HOLD_MS)
      else $error("seizure timer not loaded");
   seize_cut_a : assert property (st.seize != '0 |-> sup_out.xmt_cut)
      else $error("path not cut while seizure timer runs");
   precut_cut_a : assert property (st.precut != '0 |-> sup_out.xmt_cut)
      else $error("path not cut while precut runs");
   disc_load_a : assert property (break_s |=> st.disc == LOCAL_DISC_MS)
      else $error("disconnect timer not loaded on break");
   far_disc_a : assert property (far_disc_s |=> sup_out.xmt_cut)
      else $error("path not cut on distant disconnect");
   far_hold_a : assert property (st.far_disc |-> sup_out.xmt_cut)
      else $error("path not held cut after distant disconnect");
   cut_cause_a : assert property ((sup_out.xmt_cut && !st.far_disc && !st.dial_act && st.precut == '0
                                   && st.seize == '0) |-> (!st.prev_busy && st.disc == '0))
      else $error("path cut without a cause");

   // ==========================================================
   // timers
   // timers only move on the tick, so a stalled divider freezes every window
   div_range_a : assert property (st.div <= DIV_W'(TICK_CYCLES_P - 1))
      else $error("divider out of range");
   ins_hold_a : assert property ((!st.tick && !tone_rise && !tone_fall) |=> st.ins == $past(st.ins))
      else $error("insert timer moved without tick");
   rem_hold_a : assert property ((!st.tick && !tone_rise && !tone_fall) |=> st.rem == $past(st.rem))
      else $error("remove timer moved without tick");
   hang_hold_a : assert property ((!st.tick && !busy_edge && !tone_rise && !tone_fall) |=> st.hang == $past(st.hang))
      else $error("hang timer moved without tick");
   precut_hold_a : assert property ((!st.tick && !busy_edge) |=> st.precut == $past(st.precut))
      else $error("precut timer moved without tick");
   seize_step_a : assert property ((st.tick && st.seize != '0 && !(busy_rise && from_idle))
                                   |=> st.seize == $past(st.seize) - 1'b1)
      else $error("seizure timer not stepped on tick");

endmodule
`default_nettype wire

// File: verif/sf_far_end.sv
// far-end model: sf facility and e&m trunk answering after a fixed lag
`default_nettype none
module sf_far_end #(
   parameter int LAG = 2
) (
   input  wire logic mclk_in,
   input  wire logic tone_on_in,
   input  wire logic busy_in,
   input  wire logic b_side_in,
   output logic      tone_det_out,
   output logic      m_lead_neg_out,
   output logic      e_lead_gnd_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // lag line; lag must be two or more
   logic [LAG-1:0] tone_q = '1;
   logic [LAG-1:0] busy_q = '0;
   always @(posedge mclk_in) begin
      tone_q <= {tone_q[LAG-2:0], tone_on_in};
      busy_q <= {busy_q[LAG-2:0], busy_in};
   end
   assign tone_det_out   = tone_q[LAG-1];
   // only the incoming lead of the chosen side carries busy
   assign m_lead_neg_out = busy_q[LAG-1] & ~b_side_in;
   assign e_lead_gnd_out = busy_q[LAG-1] & b_side_in;
endmodule
`default_nettype wire

// File: verif/sf_supervision_signaling_logic_test.sv
// testbench for the sf supervision logic
`default_nettype none
module sf_supervision_signaling_logic_test;
   import sf_sup_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // set-up; short tick keeps the run brief
   localparam int T = 4;
   logic      mclk_in    = 1'b0;
   logic      sys_rst_in = 1'b1;
   logic      tone_on    = 1'b1;
   logic      busy       = 1'b0;
   logic      b_side     = 1'b0;
   logic      tone_det;
   logic      m_neg;
   logic      e_gnd;
   em_type_e  em_type    = EM_TYPE_1;
   sup_out_s  so;
   int        err_count       = 0;
   int        samples_checked = 0;
   int        cycles          = 0;
   always #25 mclk_in = ~mclk_in;
   sf_far_end u_sf_far_end (.mclk_in(mclk_in), .tone_on_in(tone_on), .busy_in(busy), .b_side_in(b_side),
                            .tone_det_out(tone_det), .m_lead_neg_out(m_neg), .e_lead_gnd_out(e_gnd));
   sf_supervision #(.TICK_CYCLES_P(T)) u_sf_supervision (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .tone_det_in(tone_det), .m_lead_neg_in(m_neg), .e_lead_gnd_in(e_gnd), .b_side_in(b_side),
      .em_type_in(em_type), .sup_out(so));
   // ==========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic ms(input int n);
      cyc(n * T);
   endtask
   task automatic chk(input string name, input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic close_out();
      if (err_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         close_out();
      end
   end
   // ==========================================================
   // scenarios
   task automatic test_a_seize();
      cyc(4);
      chk("e_lead_gnd", so.e_lead_gnd, 1'b0);
      chk("relay", so.relay, 1'b0);
      chk("tone_high", so.tone_high, 1'b0);
      busy = 1'b1;
      cyc(4);
      chk("tone_send", so.tone_send, 1'b0);
      ms(100);
      chk("xmt_cut", so.xmt_cut, 1'b1);
      ms(27);
      chk("xmt_cut", so.xmt_cut, 1'b0);
   endtask
   task automatic test_dialing();
      busy = 1'b0;
      cyc(4);
      chk("xmt_cut", so.xmt_cut, 1'b1);
      chk("tone_send", so.tone_send, 1'b1);
      chk("tone_high", so.tone_high, 1'b1);
      ms(20);
      busy = 1'b1;
      ms(100);
      chk("xmt_cut", so.xmt_cut, 1'b1);
      ms(30);
      chk("xmt_cut", so.xmt_cut, 1'b0);
   endtask
   task automatic test_filter();
      tone_on = 1'b0;
      cyc(4);
      chk("e_lead_gnd", so.e_lead_gnd, 1'b1);
      ms(45);
      chk("bsf_in", so.bsf_in, 1'b1);
      ms(7);
      chk("bsf_in", so.bsf_in, 1'b0);
      tone_on = 1'b1;
      cyc(4);
      chk("xmt_cut", so.xmt_cut, 1'b1);
      ms(10);
      chk("bsf_in", so.bsf_in, 1'b0);
      ms(4);
      chk("bsf_in", so.bsf_in, 1'b1);
   endtask
   task automatic test_b_side();
      busy   = 1'b0;
      b_side = 1'b1;
      cyc(4);
      chk("m_lead_gnd", so.m_lead_gnd, 1'b1);
      chk("relay", so.relay, 1'b1);
      chk("tone_send", so.tone_send, 1'b1);
      busy = 1'b1;
      cyc(4);
      chk("tone_send", so.tone_send, 1'b0);
      tone_on = 1'b0;
      cyc(4);
      chk("m_lead_gnd", so.m_lead_gnd, 1'b0);
      chk("relay", so.relay, 1'b0);
   endtask
   task automatic test_config();
      tone_on = 1'b1;
      for (int t = 0; t < 4; t++) begin
         em_type = em_type_e'(t);
         cyc(4);
         chk("cfg_err", so.cfg_err, (t == 2));
         chk("m_lead_gnd", so.m_lead_gnd, (t != 2));
      end
   endtask
   initial begin
      cyc(1);
      chk("tone_send", so.tone_send, 1'b1);
      chk("xmt_cut", so.xmt_cut, 1'b1);
      cyc(2);
      sys_rst_in = 1'b0;
      test_a_seize();
      test_dialing();
      test_filter();
      test_b_side();
      test_config();
      close_out();
   end
endmodule
`default_nettype wire
